// ==== step_dir_pkg.sv ====
package step_dir_pkg;
   localparam int NUM_AXES = 6;
   localparam int NUM_SWITCH_INPUTS = 5;
   localparam int CLK_HZ = 200000000;
   localparam int MAX_STEP_RATE_HZ = 35000;
   localparam int MIN_STEP_PERIOD_CYCLES = CLK_HZ / MAX_STEP_RATE_HZ;
   localparam int STEP_PULSE_NS = 2000;
   localparam int STEP_PULSE_CYCLES = (STEP_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int DIR_SETUP_NS = 1000;
   localparam int DIR_SETUP_CYCLES = (DIR_SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int PERIOD_W = 24;
   localparam int POS_W = 32;
   localparam int HOME_PERIOD_DEFAULT = 20000;
   localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
endpackage

// ==== step_pulse_channel.sv ====
`timescale 1ns/10ps
// One axis: rate timer, direction setup, fixed-width step pulse
module step_pulse_channel
   import step_dir_pkg::*;
#(
   parameter int PULSE_CYCLES = STEP_PULSE_CYCLES,
   parameter int SETUP_CYCLES = DIR_SETUP_CYCLES
)
(
   input wire logic clk_i,
   input wire logic reset_i,
   // Command
   input wire logic run_i,
   input wire logic dir_i,
   input wire logic [PERIOD_W-1:0] period_i,
   // Outputs, active-high logic level
   output logic step_o,
   output logic dir_o,
   output logic step_done_o
);
   typedef enum logic [2:0]
   {
      S_IDLE = 3'b001,
      S_SETUP = 3'b010,
      S_PULSE = 3'b100
   } ch_state_t;

   ch_state_t state;
   ch_state_t next_state;
   logic [PERIOD_W-1:0] timer;
   logic [PERIOD_W-1:0] next_timer;
   logic [PERIOD_W-1:0] gap;
   logic [PERIOD_W-1:0] next_gap;
   logic dir_q;
   logic next_dir_q;
   logic done_q;
   logic next_done_q;

   // Period is clamped to MIN_STEP_PERIOD_CYCLES (5714), a rate just above the 35000 guaranteed maximum
   function automatic logic [PERIOD_W-1:0] clamp_period(input logic [PERIOD_W-1:0] p);
      logic [PERIOD_W-1:0] lo;
      lo = PERIOD_W'(MIN_STEP_PERIOD_CYCLES);
      clamp_period = (p < lo) ? lo : p;
   endfunction

   always_comb
   begin
      next_state = state;
      next_timer = timer;
      next_gap = gap;
      next_dir_q = dir_q;
      next_done_q = 1'b0;
      if (gap != '0)
      begin
         next_gap = gap - 1'b1;
      end
      case (state)
         S_IDLE:
         begin
            if (run_i && gap == '0)
            begin
               if (dir_i != dir_q)
               begin
                  next_dir_q = dir_i; // R2
                  next_timer = PERIOD_W'(SETUP_CYCLES);
                  next_state = S_SETUP;
               end
               else
               begin
                  next_timer = PERIOD_W'(PULSE_CYCLES); // R1
                  next_gap = clamp_period(period_i) - 1'b1; // R3 R5
                  next_state = S_PULSE;
               end
            end
         end
         S_SETUP:
         begin
            if (timer <= 1)
            begin
               next_timer = PERIOD_W'(PULSE_CYCLES);
               next_gap = clamp_period(period_i) - 1'b1; // R3
               next_state = S_PULSE;
            end
            else
            begin
               next_timer = timer - 1'b1;
            end
         end
         S_PULSE:
         begin
            // Direction frozen here
            if (timer <= 1)
            begin
               next_done_q = 1'b1;
               next_state = S_IDLE;
            end
            else
            begin
               next_timer = timer - 1'b1;
            end
         end
         default:
         begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state <= S_IDLE;
         timer <= '0;
         gap <= '0;
         dir_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         state <= next_state;
         timer <= next_timer;
         gap <= next_gap;
         dir_q <= next_dir_q;
         done_q <= next_done_q;
      end
   end

   assign step_o = (state == S_PULSE);
   assign dir_o = dir_q;
   assign step_done_o = done_q;

   property p_dir_stable;
      @(posedge clk_i) disable iff (reset_i)
      step_o |=> (step_o ? $stable(dir_o) : 1'b1);
   endproperty
   a_dir_stable: assert property (p_dir_stable) else $error("dir changed in pulse"); // R18

   property p_pulse_width;
      @(posedge clk_i) disable iff (reset_i)
      $rose(step_o) |-> step_o [*2] ##1 1'b1;
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("step pulse too short"); // R1

   property p_dir_before_step;
      @(posedge clk_i) disable iff (reset_i)
      $changed(dir_o) |-> !step_o ##1 !step_o;
   endproperty
   a_dir_before_step: assert property (p_dir_before_step) else $error("dir setup violated"); // R2
endmodule

// ==== step_dir_axis_generator.sv ====
`timescale 1ns/10ps
// Function
// (R1) One step pulse per commanded step
// (R2) Direction settles before its step pulse
// (R3) Higher speed gives shorter pulse interval
// (R4) Step and direction polarity selectable
// (R5) 35000 steps per second on six axes
// (R6) Encoder gives four counts per slot
// (R7) Drive moves one count per step
// (R8) Drive may scale steps by gear ratio
// (R9) Reference one axis or all axes
// (R10) Reference at zero leaves position zero
// (R11) External limit logic disables drives
// (R12) One shared input gives limit and reference
// (R13) Three axes need three inputs, gantry four
// (R14) At most five switch inputs
// (R15) Limit during motion stops all, flags
// (R16) Limits ignored during referencing
// (R17) Seek switch slowly, back off until release
// (R18) Direction held steady through each pulse
module step_dir_axis_generator
   import step_dir_pkg::*;
#(
   parameter int AXES = NUM_AXES,
   parameter int SWITCHES = NUM_SWITCH_INPUTS,
   parameter logic [PERIOD_W-1:0] HOME_PERIOD = PERIOD_W'(HOME_PERIOD_DEFAULT)
)
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Motion command per axis
   input wire logic [AXES-1:0] RUN_I,
   input wire logic [AXES-1:0] DIR_I,
   input wire logic [AXES*step_dir_pkg::PERIOD_W-1:0] PERIOD_I,
   // Polarity: 1 means active low at the pin
   input wire logic STEP_ACTIVE_LOW_I,
   input wire logic DIR_ACTIVE_LOW_I,
   // Switches, active high, one shared input per switch group
   input wire logic [SWITCHES-1:0] SWITCH_I,
   input wire logic [AXES*3-1:0] SWITCH_SEL_I,
   // Referencing
   input wire logic HOME_START_I,
   input wire logic HOME_ALL_I,
   input wire logic [2:0] HOME_AXIS_I,
   input wire logic [AXES-1:0] HOME_DIR_I,
   input wire logic LIMIT_CLEAR_I,
   // Drive pins
   output logic [AXES-1:0] STEP_O,
   output logic [AXES-1:0] DIR_O,
   // Status
   output logic LIMIT_TRIPPED_O,
   output logic HOMING_O,
   output logic [AXES-1:0] HOMED_O,
   output logic [AXES*step_dir_pkg::POS_W-1:0] AXIS_POSITION_READOUT_O
);
   import step_dir_pkg::*;

   typedef enum logic [3:0]
   {
      H_IDLE = 4'b0001,
      H_SEEK = 4'b0010,
      H_BACKOFF = 4'b0100,
      H_NEXT = 4'b1000
   } home_state_t;

   home_state_t hstate;
   home_state_t next_hstate;
   logic [AXES-1:0] home_mask;
   logic [AXES-1:0] next_home_mask;
   logic [2:0] home_axis;
   logic [2:0] next_home_axis;
   logic tripped;
   logic next_tripped;
   logic [AXES-1:0] homed;
   logic [AXES-1:0] next_homed;
   logic [POS_W-1:0] pos [AXES];
   logic [POS_W-1:0] next_pos [AXES];
   logic [AXES-1:0] ch_run;
   logic [AXES-1:0] ch_dir;
   logic [AXES-1:0] ch_step;
   logic [AXES-1:0] ch_dir_out;
   logic [AXES-1:0] ch_done;
   logic [AXES-1:0] axis_sw;
   logic [AXES-1:0] moving;
   logic [AXES-1:0] step_pin;
   logic [AXES-1:0] dir_pin;
   logic cur_sw;

   // Map an axis to its shared switch input
   function automatic logic sw_of(input logic [SWITCHES-1:0] sw, input logic [2:0] sel);
      sw_of = (int'(sel) < SWITCHES) ? sw[sel] : 1'b0;
   endfunction

   always_comb
   begin
      for (int a = 0; a < AXES; a++)
      begin
         axis_sw[a] = sw_of(SWITCH_I, SWITCH_SEL_I[a*3 +: 3]); // R12 R13 R14
      end
   end

   assign cur_sw = axis_sw[home_axis];

   // Channel command mux: homing owns the axis being referenced
   always_comb
   begin
      for (int a = 0; a < AXES; a++)
      begin
         ch_run[a] = 1'b0;
         ch_dir[a] = DIR_I[a];
         if (hstate == H_SEEK && int'(home_axis) == a)
         begin
            ch_run[a] = 1'b1; // R17
            ch_dir[a] = HOME_DIR_I[a];
         end
         else if (hstate == H_BACKOFF && int'(home_axis) == a)
         begin
            ch_run[a] = 1'b1;
            ch_dir[a] = ~HOME_DIR_I[a]; // R17
         end
         else if (hstate == H_IDLE && !tripped)
         begin
            ch_run[a] = RUN_I[a];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < AXES; g++)
      begin : g_ch
         logic [PERIOD_W-1:0] per;
         assign per = (hstate != H_IDLE) ? HOME_PERIOD : PERIOD_I[g*PERIOD_W +: PERIOD_W];
         step_pulse_channel u_ch
         (
            .clk_i(CLK_I),
            .reset_i(RESET_I),
            .run_i(ch_run[g]),
            .dir_i(ch_dir[g]),
            .period_i(per),
            .step_o(ch_step[g]),
            .dir_o(ch_dir_out[g]),
            .step_done_o(ch_done[g])
         );
      end
   endgenerate

   assign moving = ch_run | ch_step;

   // Homing sequencer, limit supervision and position counters
   always_comb
   begin
      next_hstate = hstate;
      next_home_mask = home_mask;
      next_home_axis = home_axis;
      next_tripped = tripped;
      next_homed = homed;
      for (int a = 0; a < AXES; a++)
      begin
         next_pos[a] = pos[a];
         if (ch_done[a])
         begin
            next_pos[a] = ch_dir_out[a] ? pos[a] - 1'b1 : pos[a] + 1'b1;
         end
      end
      if (LIMIT_CLEAR_I)
      begin
         next_tripped = 1'b0;
      end
      // A trip in the same cycle as a clear still wins
      if (hstate == H_IDLE && |(axis_sw & moving & RUN_I))
      begin
         next_tripped = 1'b1; // R15
      end
      case (hstate)
         H_IDLE:
         begin
            if (HOME_START_I && !tripped)
            begin
               if (HOME_ALL_I) // R9
               begin
                  next_home_mask = {AXES{1'b1}};
                  next_home_axis = 3'h0;
               end
               else
               begin
                  next_home_mask = '0;
                  next_home_mask[HOME_AXIS_I] = 1'b1;
                  next_home_axis = HOME_AXIS_I;
               end
               // Always enter seek first; seek moves to back-off if already on the switch
               next_hstate = H_SEEK;
            end
         end
         H_SEEK:
         begin
            // Switch here means reference, not a limit
            if (cur_sw)
            begin
               next_hstate = H_BACKOFF; // R16
            end
         end
         H_BACKOFF:
         begin
            if (!cur_sw && !ch_step[home_axis])
            begin
               next_pos[home_axis] = POS_RESET; // R10
               next_homed[home_axis] = 1'b1;
               next_hstate = H_NEXT;
            end
         end
         H_NEXT:
         begin
            // Wait for the channel to go quiet before the next axis
            if (ch_step == '0)
            begin
               if (HOME_ALL_I && home_mask == {AXES{1'b1}} && int'(home_axis) < AXES - 1)
               begin
                  next_home_axis = home_axis + 3'h1;
                  next_hstate = H_SEEK;
               end
               else
               begin
                  next_home_mask = '0;
                  next_hstate = H_IDLE;
               end
            end
         end
         default:
         begin
            next_hstate = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         hstate <= H_IDLE;
         home_mask <= '0;
         home_axis <= 3'h0;
         tripped <= 1'b0;
         homed <= '0;
         for (int a = 0; a < AXES; a++)
         begin
            pos[a] <= POS_RESET;
         end
      end
      else
      begin
         hstate <= next_hstate;
         home_mask <= next_home_mask;
         home_axis <= next_home_axis;
         tripped <= next_tripped;
         homed <= next_homed;
         for (int a = 0; a < AXES; a++)
         begin
            pos[a] <= next_pos[a];
         end
      end
   end

   // Registered pins so polarity changes never glitch the drive
   always_comb
   begin
      step_pin = ch_step ^ {AXES{STEP_ACTIVE_LOW_I}}; // R4
      dir_pin = ch_dir_out ^ {AXES{DIR_ACTIVE_LOW_I}}; // R4
   end

   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         STEP_O <= '0;
         DIR_O <= '0;
      end
      else
      begin
         STEP_O <= step_pin;
         DIR_O <= dir_pin;
      end
   end

   always_comb
   begin
      for (int a = 0; a < AXES; a++)
      begin
         AXIS_POSITION_READOUT_O[a*POS_W +: POS_W] = pos[a];
      end
   end

   assign LIMIT_TRIPPED_O = tripped;
   assign HOMING_O = (hstate != H_IDLE);
   assign HOMED_O = homed;

   property p_trip_stops;
      @(posedge CLK_I) disable iff (RESET_I)
      (tripped && hstate == H_IDLE) |-> (ch_run == '0);
   endproperty
   a_trip_stops: assert property (p_trip_stops) else $error("motion while tripped"); // R15

   property p_no_trip_homing;
      @(posedge CLK_I) disable iff (RESET_I)
      (hstate != H_IDLE && !tripped) |=> !tripped;
   endproperty
   a_no_trip_homing: assert property (p_no_trip_homing) else $error("trip during homing"); // R16

   property p_home_zero;
      @(posedge CLK_I) disable iff (RESET_I)
      (hstate == H_BACKOFF && next_hstate == H_NEXT) |=> (pos[home_axis] == POS_RESET);
   endproperty
   a_home_zero: assert property (p_home_zero) else $error("position not zero after home"); // R10

   property p_seek_dir;
      @(posedge CLK_I) disable iff (RESET_I)
      (hstate == H_SEEK) |-> ch_run[home_axis] && ch_dir[home_axis] == HOME_DIR_I[home_axis];
   endproperty
   a_seek_dir: assert property (p_seek_dir) else $error("seek direction wrong"); // R17

   property p_step_pol;
      @(posedge CLK_I) disable iff (RESET_I)
      1'b1 |=> STEP_O == ($past(ch_step) ^ {AXES{$past(STEP_ACTIVE_LOW_I)}});
   endproperty
   a_step_pol: assert property (p_step_pol) else $error("step polarity wrong"); // R4
endmodule

// ==== step_drive_model.sv ====
`timescale 1ns/10ps
// Drive side of the step and direction pins; GEAR counts per step start
module step_drive_model
   import step_dir_pkg::*;
#(
   parameter int N = 6,
   parameter int GEAR = 1
)
(
   input wire logic clk_i,
   input wire logic [N-1:0] step_i,
   input wire logic [N-1:0] dir_i,
   input wire logic step_low_i,
   input wire logic dir_low_i,
   input wire logic [N-1:0] limit_i,
   output int count_o [N],
   output int slot_o [N],
   output int dir_err_o
);
   localparam int COUNTS_PER_SLOT = 4;
   logic sl_q = 1'b0;
   logic dl_q = 1'b0;
   logic [N-1:0] s_q = '0;
   logic [N-1:0] d_q = '0;
   logic [N-1:0] s;
   logic [N-1:0] d;
   int age [N];
   // Pins take the polarity one clock late, so compare against delayed copy
   assign s = step_i ^ {N{sl_q}};
   assign d = dir_i ^ {N{dl_q}};
   initial
   begin
      dir_err_o = 0;
      for (int i = 0; i < N; i++)
      begin
         count_o[i] = 0;
         slot_o[i] = 0;
         age[i] = DIR_SETUP_CYCLES;
      end
   end
   always @(posedge clk_i)
   begin
      for (int i = 0; i < N; i++)
      begin
         // Age first, so a change on the step edge itself counts as late
         age[i] = (d[i] !== d_q[i]) ? 0 : age[i] + 1;
         if (s[i] && !s_q[i])
         begin
            if (age[i] < DIR_SETUP_CYCLES)
               dir_err_o++;
            // External limit logic holds the drive off
            if (!limit_i[i])
               count_o[i] += d[i] ? -GEAR : GEAR;
         end
         slot_o[i] = count_o[i] / COUNTS_PER_SLOT;
         if (s[i] && s_q[i] && d[i] !== d_q[i])
            dir_err_o++;
      end
      s_q <= s;
      d_q <= d;
      sl_q <= step_low_i;
      dl_q <= dir_low_i;
   end
endmodule

// ==== step_dir_axis_generator_bench.sv ====
`timescale 1ns/10ps
module step_dir_axis_generator_bench;
   import step_dir_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] run = '0;
   logic [5:0] dir = '0;
   logic [5:0] hdir = '0;
   logic [143:0] per = {6{24'h001770}};
   logic sl = 1'b0;
   logic dl = 1'b0;
   logic [4:0] sw = '0;
   logic [17:0] sel = {6{3'h7}};
   logic hs = 1'b0;
   logic ha = 1'b0;
   logic [2:0] hax = '0;
   logic lc = 1'b0;
   logic [5:0] step;
   logic [5:0] dpin;
   logic [5:0] homed;
   logic trip;
   logic homing;
   logic [191:0] pos;
   int cnt [6];
   int slots [6];
   int derr;
   int n_fail = 0;
   int check_count = 0;

   step_dir_axis_generator #(.AXES(6), .SWITCHES(5), .HOME_PERIOD(24'h001770)) DUT (
      .CLK_I(clk), .RESET_I(rst), .RUN_I(run), .DIR_I(dir), .PERIOD_I(per),
      .STEP_ACTIVE_LOW_I(sl), .DIR_ACTIVE_LOW_I(dl), .SWITCH_I(sw),
      .SWITCH_SEL_I(sel), .HOME_START_I(hs), .HOME_ALL_I(ha), .HOME_AXIS_I(hax),
      .HOME_DIR_I(hdir), .LIMIT_CLEAR_I(lc), .STEP_O(step), .DIR_O(dpin),
      .LIMIT_TRIPPED_O(trip), .HOMING_O(homing), .HOMED_O(homed),
      .AXIS_POSITION_READOUT_O(pos));

   step_drive_model #(.N(6), .GEAR(1)) drive (
      .clk_i(clk), .step_i(step), .dir_i(dpin), .step_low_i(sl),
      .dir_low_i(dl), .limit_i({5'h0, sw[0]}), .count_o(cnt), .slot_o(slots),
      .dir_err_o(derr));

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Samples on the falling edge, clear of the design's updates
   task automatic wait_step(input int a, input logic v, input int m, output int n);
      n = 0;
      while ((step[a] ^ sl) !== v && n < m)
      begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic settle(input int a);
      int n;
      @(posedge clk);
      run[a] <= 1'b0;
      wait_step(a, 1'b0, 500, n);
      repeat (20) @(negedge clk);
      check(pos[a*32 +: 32], 32'(cnt[a]));
      check(32'(slots[a]), 32'($signed(pos[a*32 +: 32]) / 4));
      check(32'(derr), 32'h0);
   endtask

   task automatic t_rate;
      int n;
      int w;
      int g;
      @(posedge clk);
      run[0] <= 1'b1;
      wait_step(0, 1'b1, 20, n);
      wait_step(0, 1'b0, 9000, w);
      check(32'(w), 32'(STEP_PULSE_CYCLES));
      wait_step(0, 1'b1, 9000, g);
      check(32'(w + g), 32'h1770);
      @(posedge clk);
      per[23:0] <= 24'h000064;
      wait_step(0, 1'b0, 9000, n);
      wait_step(0, 1'b1, 9000, n);
      wait_step(0, 1'b0, 9000, w);
      wait_step(0, 1'b1, 9000, g);
      check(32'(w + g), 32'(MIN_STEP_PERIOD_CYCLES));
      settle(0);
      $display("t_rate done");
   endtask

   task automatic t_dir;
      int n;
      @(posedge clk);
      run[0] <= 1'b1;
      per[23:0] <= 24'h001770;
      wait_step(0, 1'b1, 20, n);
      @(posedge clk);
      dir[0] <= 1'b1;
      repeat (2)
      begin
         wait_step(0, 1'b0, 9000, n);
         wait_step(0, 1'b1, 9000, n);
      end
      check(32'(dpin[0] ^ dl), 32'h1);
      settle(0);
      $display("t_dir done");
   endtask

   task automatic t_pol;
      int n;
      @(posedge clk);
      sl <= 1'b1;
      dl <= 1'b1;
      repeat (3) @(negedge clk);
      check(32'(step[0]), 32'h1);
      check(32'(dpin[0]), 32'h0);
      @(posedge clk);
      run[0] <= 1'b1;
      wait_step(0, 1'b1, 9000, n);
      check(32'(step[0]), 32'h0);
      settle(0);
      $display("t_pol done");
   endtask

   task automatic t_limit;
      int n;
      @(posedge clk);
      sel[2:0] <= 3'h0;
      run[0] <= 1'b1;
      wait_step(0, 1'b1, 9000, n);
      @(posedge clk);
      sw[0] <= 1'b1;
      repeat (4) @(negedge clk);
      check(32'(trip), 32'h1);
      wait_step(0, 1'b0, 500, n);
      wait_step(0, 1'b1, 8000, n);
      check(32'(n), 32'h1f40);
      check(pos[31:0], 32'(cnt[0]));
      @(posedge clk);
      sw[0] <= 1'b0;
      run[0] <= 1'b0;
      lc <= 1'b1;
      @(posedge clk);
      lc <= 1'b0;
      repeat (3) @(negedge clk);
      check(32'(trip), 32'h0);
      $display("t_limit done");
   endtask

   task automatic t_home;
      int n;
      @(posedge clk);
      sel[5:3] <= 3'h1;
      hax <= 3'h1;
      hs <= 1'b1;
      @(posedge clk);
      hs <= 1'b0;
      repeat (3) @(negedge clk);
      check(32'(homing), 32'h1);
      wait_step(1, 1'b1, 9000, n);
      check(32'(dpin[1] ^ dl), 32'h0);
      wait_step(1, 1'b0, 500, n);
      @(posedge clk);
      sw[1] <= 1'b1;
      wait_step(1, 1'b1, 14000, n);
      check(32'(trip), 32'h0);
      check(32'(dpin[1] ^ dl), 32'h1);
      wait_step(1, 1'b0, 500, n);
      @(posedge clk);
      sw[1] <= 1'b0;
      n = 0;
      while (homing !== 1'b0 && n < 20000)
      begin
         @(negedge clk);
         n++;
      end
      check(32'(homing), 32'h0);
      check(32'(homed), 32'h2);
      check(pos[63:32], 32'h0);
      $display("t_home done");
   endtask

   task finish_test;
      $display("checks=%0d fails=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Tests need about 57000 cycles
   initial
   begin
      #450000;
      n_fail++;
      finish_test;
   end

   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_rate;
      t_dir;
      t_pol;
      t_limit;
      t_home;
      finish_test;
   end
endmodule
